// file: rtl/ccr_defines.vh
// Constants of the core clock and reset control block
`ifndef CCR_DEFINES_VH
`define CCR_DEFINES_VH
// APB byte offsets
`define CCR_OFF_POWER_MODE 12'h000
`define CCR_OFF_STATUS 12'h004
// Power mode control register fields
`define CCR_MULT_LSB 0
`define CCR_MULT_MSB 6
`define CCR_DIV_LSB 8
`define CCR_DIV_MSB 10
`define CCR_PIN_SEL_BIT 12
// Status register fields
`define CCR_ST_RATIO_LSB 0
`define CCR_ST_RATIO_MSB 1
`define CCR_ST_IN_RESET_BIT 4
`define CCR_ST_LOCKED_BIT 5
`define CCR_ST_PLL_SRC_BIT 6
// Ratio strap codes and start-up multipliers
`define CCR_RATIO_3 2'h0
`define CCR_RATIO_16 2'h1
`define CCR_RATIO_8 2'h2
`define CCR_RATIO_RSVD 2'h3
`define CCR_MULT_3 7'h03
`define CCR_MULT_16 7'h10
`define CCR_MULT_8 7'h08
`define CCR_DIV_RESET 3'h1
// PLL lock interval in input clock cycles
`define CCR_LOCK_CYCLES 4096
`endif

// file: rtl/ccr_lock_timer.v
// Counter that measures the PLL lock interval after reset release
`timescale 1ns/1ps
module ccr_lock_timer #(
    parameter WIDTH = 13,
    parameter CYCLES = 4096
) (
    input wire sys_clk,
    input wire resetn,
    output reg done
);
    reg [WIDTH-1:0] count;
    // ============================================================
    // Lock counter
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count <= {WIDTH{1'b0}};
            done <= 1'b0;
        end else if (!done) begin
            if (count == CYCLES[WIDTH-1:0] - 1'b1) begin
                done <= 1'b1;
            end
            count <= count + 1'b1;
        end
    end
endmodule // ccr_lock_timer

// file: rtl/ccr_core_clock_reset_control.v
// Core clock source, start-up reset sequencing, shared reset/clock pin and test port
//
// How it works
// - Core clock comes from PLL or straight from reference, chosen by strap.
// - Two-bit ratio strap sampled once, as the device leaves reset.
// - Strap 00 gives 3x, 01 gives 16x, 10 gives 8x, 11 reserved.
// - After core reset ends, software may rewrite PLL multiplier and divider.
// - Bit 12 picks PLL clock or core reset for shared pin; reset default.
// - In reset mode the shared pin shows the internal core reset state.
// - After reset release wait 4096 input cycles, then start at reset vector.
// - Test reset low resets the test state machine; board pulses or holds it.
// - TMS steers test state machine, TDI shifts in, TDO shifts out.
`timescale 1ns/1ps
`include "ccr_defines.vh"
module ccr_core_clock_reset_control #(
    parameter LOCK_CYCLES = `CCR_LOCK_CYCLES,
    parameter LOCK_WIDTH = 13,
    parameter SCAN_LEN = 8
) (
    input wire sys_clk,
    input wire resetn,
    input wire [1:0] core_clock_ratio_select,
    input wire pll_clock_level,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg core_reset_n,
    output reg core_start,
    output reg core_clock_from_pll,
    output reg [6:0] pll_multiplier,
    output reg [2:0] pll_divider,
    output reg reset_or_clock_output,
    input wire tck,
    input wire trst_n,
    input wire tms,
    input wire tdi,
    output reg tdo,
    output reg tdo_oe
);
    // ============================================================
    // TAP states
    localparam [3:0] ST_RESET = 4'h0;
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_SEL_DR = 4'h2;
    localparam [3:0] ST_CAP_DR = 4'h3;
    localparam [3:0] ST_SH_DR = 4'h4;
    localparam [3:0] ST_EX1_DR = 4'h5;
    localparam [3:0] ST_PA_DR = 4'h6;
    localparam [3:0] ST_EX2_DR = 4'h7;
    localparam [3:0] ST_UP_DR = 4'h8;
    localparam [3:0] ST_SEL_IR = 4'h9;
    localparam [3:0] ST_CAP_IR = 4'hA;
    localparam [3:0] ST_SH_IR = 4'hB;
    localparam [3:0] ST_EX1_IR = 4'hC;
    localparam [3:0] ST_PA_IR = 4'hD;
    localparam [3:0] ST_EX2_IR = 4'hE;
    localparam [3:0] ST_UP_IR = 4'hF;

    wire locked;
    reg strap_taken;
    reg [1:0] ratio;
    reg pin_sel_clock;
    reg [3:0] tap;
    reg [3:0] next_tap;
    reg tck_prev;
    reg [SCAN_LEN-1:0] scan;
    reg [SCAN_LEN-1:0] scan_hold;
    reg [31:0] next_rdata;
    reg next_err;
    wire acc_write;
    wire tck_rise;
    wire tck_fall;

    // ============================================================
    // Lock interval
    ccr_lock_timer #(
        .WIDTH(LOCK_WIDTH),
        .CYCLES(LOCK_CYCLES)
    ) i_ccr_lock_timer (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .done(locked)
    );

    // ============================================================
    // Strap capture and core clock source
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            strap_taken <= 1'b0;
            ratio <= `CCR_RATIO_3;
            core_clock_from_pll <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            ratio <= core_clock_ratio_select;
            core_clock_from_pll <= (core_clock_ratio_select != `CCR_RATIO_RSVD);
        end
    end

    // ============================================================
    // Core reset sequencing
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            core_reset_n <= 1'b0;
            core_start <= 1'b0;
        end else begin
            core_reset_n <= locked;
            // one pulse to fetch reset vector
            core_start <= locked & ~core_reset_n;
        end
    end

    // ============================================================
    // APB slave, no wait state, access phase answers at once
    assign acc_write = psel & penable & pready & pwrite;

    always @* begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        if (paddr == `CCR_OFF_POWER_MODE) begin
            next_rdata[`CCR_MULT_MSB:`CCR_MULT_LSB] = pll_multiplier;
            next_rdata[`CCR_DIV_MSB:`CCR_DIV_LSB] = pll_divider;
            next_rdata[`CCR_PIN_SEL_BIT] = pin_sel_clock;
        end else if (paddr == `CCR_OFF_STATUS) begin
            next_rdata[`CCR_ST_RATIO_MSB:`CCR_ST_RATIO_LSB] = ratio;
            next_rdata[`CCR_ST_IN_RESET_BIT] = ~core_reset_n;
            next_rdata[`CCR_ST_LOCKED_BIT] = locked;
            next_rdata[`CCR_ST_PLL_SRC_BIT] = core_clock_from_pll;
            next_err = pwrite;
        end else begin
            next_err = 1'b1;
        end
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            if (psel & ~penable) begin
                prdata <= pwrite ? 32'h0000_0000 : next_rdata;
                pslverr <= next_err;
            end else begin
                prdata <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    // ============================================================
    // Power mode control register
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pll_multiplier <= `CCR_MULT_3;
            pll_divider <= `CCR_DIV_RESET;
            pin_sel_clock <= 1'b0;
        end else if (!strap_taken) begin
            case (core_clock_ratio_select)
                `CCR_RATIO_16: pll_multiplier <= `CCR_MULT_16;
                `CCR_RATIO_8: pll_multiplier <= `CCR_MULT_8;
                default: pll_multiplier <= `CCR_MULT_3;
            endcase
        end else if (acc_write && core_reset_n && paddr == `CCR_OFF_POWER_MODE) begin
            pll_multiplier <= pwdata[`CCR_MULT_MSB:`CCR_MULT_LSB];
            pll_divider <= pwdata[`CCR_DIV_MSB:`CCR_DIV_LSB];
            pin_sel_clock <= pwdata[`CCR_PIN_SEL_BIT];
        end
    end

    // ============================================================
    // Shared reset/clock pin
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reset_or_clock_output <= 1'b0;
        end else begin
            reset_or_clock_output <= pin_sel_clock ? pll_clock_level : core_reset_n;
        end
    end

    // ============================================================
    // Test port, test clock sampled as a synchronous level
    // Idle-low test clock gives no false edge after power-up
    // test clock edge detect
    assign tck_rise = tck & ~tck_prev;
    assign tck_fall = ~tck & tck_prev;

    always @* begin
        next_tap = tap;
        case (tap)
            ST_RESET: next_tap = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: next_tap = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_tap = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_tap = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: next_tap = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_tap = tms ? ST_UP_DR : ST_PA_DR;
            ST_PA_DR: next_tap = tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: next_tap = tms ? ST_UP_DR : ST_SH_DR;
            ST_UP_DR: next_tap = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_tap = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: next_tap = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: next_tap = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_tap = tms ? ST_UP_IR : ST_PA_IR;
            ST_PA_IR: next_tap = tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: next_tap = tms ? ST_UP_IR : ST_SH_IR;
            default: next_tap = tms ? ST_SEL_DR : ST_IDLE;
        endcase
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tck_prev <= 1'b0;
            tap <= ST_RESET;
            scan <= {SCAN_LEN{1'b0}};
            scan_hold <= {SCAN_LEN{1'b0}};
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (!trst_n) begin
            tck_prev <= tck;
            tap <= ST_RESET;
            tdo_oe <= 1'b0;
        end else begin
            tck_prev <= tck;
            if (tck_rise) begin
                tap <= next_tap;
                if (tap == ST_CAP_DR) begin
                    scan <= scan_hold;
                end else if (tap == ST_SH_DR) begin
                    scan <= {tdi, scan[SCAN_LEN-1:1]};
                end else if (tap == ST_UP_DR) begin
                    scan_hold <= scan;
                end
            end
            if (tck_fall) begin
                tdo <= scan[0];
                tdo_oe <= (tap == ST_SH_DR);
            end
        end
    end
endmodule // ccr_core_clock_reset_control

// file: bench/ccr_checker.sv
// Port assertions for the core clock and reset control block
`timescale 1ns/1ps
`include "ccr_defines.vh"
module ccr_checker #(
    parameter LOCK_CYCLES = 4096
) (
    input wire sys_clk,
    input wire resetn,
    input wire [1:0] core_clock_ratio_select,
    input wire pll_clock_level,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire core_reset_n,
    input wire core_start,
    input wire core_clock_from_pll,
    input wire [6:0] pll_multiplier,
    input wire [2:0] pll_divider,
    input wire reset_or_clock_output,
    input wire tck,
    input wire trst_n,
    input wire tdo,
    input wire tdo_oe
);
    // ==========================================
    // Helper logic
    logic [15:0] cnt;
    logic sel;
    wire pw = psel && penable && pready && pwrite && paddr == 12'h000;
    wire [6:0] w_mult = pwdata[6:0];
    wire [2:0] w_div = pwdata[10:8];
    wire pin_src = sel ? pll_clock_level : core_reset_n;
    wire [1:0] s = core_clock_ratio_select;
    // Saturates so a long run never wraps back into the lock window
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 16'h0000;
            sel <= 1'b0;
        end else begin
            if (cnt != 16'hFFFF) cnt <= cnt + 16'h0001;
            if (pw && core_reset_n) sel <= pwdata[12];
        end
    end
    // ==========================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    a_source_from_strap: assert property (cnt == 16'h0001 |->
        core_clock_from_pll == ($past(s) != 2'h3) ##1 $stable(core_clock_from_pll)[*4])
        else $error("core clock source wrong");
    a_ratio_decode: assert property (cnt == 16'h0001 && $past(s) != 2'h3 |->
        pll_multiplier == ($past(s) == 2'h0 ? `CCR_MULT_3 : $past(s) == 2'h1 ? `CCR_MULT_16 :
        `CCR_MULT_8)) else $error("start multiplier wrong");
    a_pll_write: assert property (pw && core_reset_n |=>
        pll_multiplier == $past(w_mult) && pll_divider == $past(w_div))
        else $error("pll write lost");
    a_write_in_reset: assert property (pw && !core_reset_n |=>
        $stable(pll_multiplier) && $stable(pll_divider)) else $error("write taken in reset");
    a_shared_pin_mux: assert property (reset_or_clock_output == $past(pin_src))
        else $error("shared pin wrong");
    a_lock_hold: assert property (core_reset_n == (cnt > LOCK_CYCLES))
        else $error("lock interval wrong");
    a_start_pulse: assert property ($rose(core_reset_n) |-> core_start ##1 !core_start)
        else $error("start pulse wrong");
    a_test_reset: assert property (!trst_n |=> !tdo_oe)
        else $error("test output enabled in test reset");
    a_tdo_on_fall: assert property ($past(trst_n) && ($changed(tdo) || $changed(tdo_oe)) |->
        !$past(tck) && $past(tck, 2)) else $error("test output moved off a test clock fall");
endmodule // ccr_checker

bind ccr_core_clock_reset_control ccr_checker #(.LOCK_CYCLES(LOCK_CYCLES)) i_ccr_checker (
    .sys_clk(sys_clk), .resetn(resetn), .core_clock_ratio_select(core_clock_ratio_select),
    .pll_clock_level(pll_clock_level), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .core_reset_n(core_reset_n),
    .core_start(core_start), .core_clock_from_pll(core_clock_from_pll),
    .pll_multiplier(pll_multiplier), .pll_divider(pll_divider),
    .reset_or_clock_output(reset_or_clock_output), .tck(tck), .trst_n(trst_n), .tdo(tdo),
    .tdo_oe(tdo_oe));

// file: bench/ccr_board_model.sv
// Board logic model: PLL level, test clock and test port inputs
`timescale 1ns/1ps
module ccr_board_model (
    input wire sys_clk,
    input wire resetn,
    output logic pll_clock_level,
    output logic tck,
    output logic trst_n,
    output logic tms,
    output logic tdi
);
    logic [2:0] ph;
    initial begin
        {pll_clock_level, tck, trst_n, tms, tdi, ph} = 8'h00;
    end
    always @(posedge sys_clk) begin
        ph <= ph + 3'h1;
        pll_clock_level <= ~pll_clock_level;
        trst_n <= resetn;
        // test clock starts low, well below half rate
        if (ph == 3'h7) tck <= ~tck;
        if (ph == 3'h7 && tck) begin
            tms <= 1'($urandom);
            tdi <= 1'($urandom);
        end
    end
endmodule // ccr_board_model

// file: bench/ccr_core_clock_reset_control_tb_top.sv
// Self-checking bench of the core clock and reset control block
`timescale 1ns/1ps
`include "ccr_defines.vh"
module ccr_core_clock_reset_control_tb_top;
    localparam LOCK = 16;
    logic sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [1:0] strap = 2'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, rd, d, since;
    wire [31:0] prdata;
    wire pready, pslverr, c_rst_n, c_start, src, pin, pll, tck, trst_n, tms, tdi;
    wire [6:0] mult;
    wire [2:0] div;
    int errors = 0, comparisons = 0, n;
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk or negedge resetn) since <= resetn ? since + 32'h1 : 32'h0;
    ccr_core_clock_reset_control #(.LOCK_CYCLES(LOCK), .LOCK_WIDTH(5))
        i_ccr_core_clock_reset_control (
        .sys_clk(sys_clk), .resetn(resetn), .core_clock_ratio_select(strap),
        .pll_clock_level(pll), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_reset_n(c_rst_n), .core_start(c_start), .core_clock_from_pll(src),
        .pll_multiplier(mult), .pll_divider(div), .reset_or_clock_output(pin), .tck(tck),
        .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(), .tdo_oe());
    ccr_board_model i_ccr_board_model (.sys_clk(sys_clk), .resetn(resetn),
        .pll_clock_level(pll), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi));
    // ==========================================
    // Tasks and expectations
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int t;
        t = 0;
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && t < 50) begin
            @(posedge sys_clk);
            t++;
        end
        if (t == 50) errors++;
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    function automatic logic [31:0] exp_status(input logic [1:0] s, input logic r);
        return {25'h0, s != 2'h3, !r, r, 2'h0, s};
    endfunction
    function automatic logic [6:0] exp_mult(input logic [1:0] s);
        return s == 2'h0 ? `CCR_MULT_3 : s == 2'h1 ? `CCR_MULT_16 : `CCR_MULT_8;
    endfunction
    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================
    // Tests
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end
    initial begin
        n = $urandom(28);
        for (int s = 0; s < 4; s++) begin
            // reset held low for 20 cycles
            @(posedge sys_clk);
            {resetn, strap} <= {1'b0, 2'(s)};
            repeat (20) @(posedge sys_clk);
            resetn <= 1'b1;
            apb(1'b0, 12'h004, 32'h0);
            check_val(rd, exp_status(2'(s), 1'b1));
            check_val(32'(src), 32'(s != 3));
            if (s != 3) check_val(32'(mult), 32'(exp_mult(2'(s))));
            apb(1'b1, 12'h000, 32'h00000255);
            // Let a wrongly taken write show before looking
            @(posedge sys_clk);
            if (s != 3) check_val(32'(mult), 32'(exp_mult(2'(s))));
            check_val(32'(pin), 32'h0);
            while (c_start !== 1'b1 && since < 32'h100) @(posedge sys_clk);
            check_val(since, LOCK + 1);
            @(posedge sys_clk);
            check_val(32'(pin), 32'h1);
            $display("test strap %0d done", s);
        end
        repeat (6) begin
            d = $urandom & 32'h0000077F;
            apb(1'b1, 12'h000, d);
            @(posedge sys_clk);
            check_val({22'h0, div, mult}, {22'h0, d[10:8], d[6:0]});
            apb(1'b0, 12'h000, 32'h0);
            check_val(rd, d);
        end
        $display("test pll write done");
        apb(1'b1, 12'h000, 32'h00001103);
        repeat (3) @(posedge sys_clk);
        repeat (4) begin
            @(posedge sys_clk);
            #1 check_val(32'(pin), 32'(!pll));
        end
        apb(1'b1, 12'h000, 32'h00000103);
        repeat (2) @(posedge sys_clk);
        check_val(32'(pin), 32'h1);
        $display("test shared pin done");
        apb(1'b1, 12'h004, 32'hFFFFFFFF);
        check_val(32'(er), 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        check_val(rd, exp_status(2'h3, 1'b0));
        repeat (4) begin
            apb(1'(n), 12'h008 | (12'($urandom) & 12'hFF0), $urandom);
            check_val(32'(er), 32'h1);
            check_val(rd, 32'h0);
        end
        $display("test refusals done");
        tally_and_finish();
    end
endmodule // ccr_core_clock_reset_control_tb_top
